/* File: src/hms_standby_ctl.sv */
// Hardware standby sequencer, module stop register and APB register file.
// Assumes pins synchronous to core_clk and an APB master with no wait needs.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module hms_standby_ctl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power pins
  input wire logic hw_standby_n,
  input wire logic reset_in_n,
  input wire logic [2:0] modeSelectPin,
  // Operating mode from the core
  input wire logic swStandby,
  input wire logic sleepMode,
  // Module events
  input wire logic [3:0] modEvent,
  // Sequencer outputs
  output logic oscRun,
  output logic cpuHalt,
  output logic moduleRst,
  output logic resetExc,
  output logic progRun,
  output logic ramHold,
  output logic [2:0] modeLatched,
  // Module and pin control
  output hms_pkg::hms_pin_ctl_t pinCtl,
  output logic [3:0] modHalt,
  output logic [31:0] modRegs,
  output logic clkPin,
  output logic clkPinOe
);
  hms_pkg::hms_state_t state_ff;
  hms_pkg::hms_state_t nxt_state;
  logic [7:0] mstop_ff;
  logic [7:0] sysctl_ff;
  logic [3:0] stopEff_ff;
  logic [2:0] mode_ff;
  logic [31:0] prdata_ff;
  logic [3:0] stopReq;
  logic [31:0] modRd;
  logic [3:0] modWr;
  logic setup;
  logic wrAcc;
  logic hwStby;
  logic mapped;
  logic [7:0] rdSel;

  // ==========================================================
  // Sequencer
  // Next state; standby pin wins from every state
  always_comb begin
    nxt_state = state_ff;
    if (!hw_standby_n) begin
      nxt_state = hms_pkg::ST_HW_STANDBY_N;
    end else begin
      unique case (state_ff)
        hms_pkg::ST_RESET: begin
          if (reset_in_n) begin
            nxt_state = hms_pkg::ST_EXC;
          end
        end
        hms_pkg::ST_HW_STANDBY_N: begin
          // Reset still low: oscillator starts and waits
          nxt_state = reset_in_n ? hms_pkg::ST_EXC : hms_pkg::ST_OSC;
        end
        hms_pkg::ST_OSC: begin
          if (reset_in_n) begin
            nxt_state = hms_pkg::ST_EXC;
          end
        end
        hms_pkg::ST_EXC: begin
          nxt_state = hms_pkg::ST_RUN;
        end
        hms_pkg::ST_RUN: begin
          if (!reset_in_n) begin
            nxt_state = hms_pkg::ST_RESET;
          end
        end
        default: begin
          nxt_state = hms_pkg::ST_RESET;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= hms_pkg::ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Sequencer decode
  assign hwStby = (state_ff == hms_pkg::ST_HW_STANDBY_N);
  assign oscRun = !hwStby;
  assign moduleRst = hwStby || (state_ff == hms_pkg::ST_OSC) ||
                     (state_ff == hms_pkg::ST_RESET);
  assign cpuHalt = moduleRst;
  assign resetExc = (state_ff == hms_pkg::ST_EXC);
  assign progRun = (state_ff == hms_pkg::ST_RUN);
  // RAM keeps data only while its enable bit was cleared beforehand
  assign ramHold = hwStby && !sysctl_ff[hms_pkg::BIT_RAM_ENABLE_BIT];

  // Mode strap caught as reset exception runs, not under async reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= 3'h0;
    end else if (state_ff == hms_pkg::ST_EXC) begin
      mode_ff <= modeSelectPin;
    end
  end
  assign modeLatched = mode_ff;

  // ==========================================================
  // APB access
  // Zero wait states; writes land in the access phase unless module reset is active
  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pwrite && !moduleRst;
  assign mapped = (paddr == hms_pkg::OFF_MSTOP) || (paddr == hms_pkg::OFF_SYSCTL) ||
                  (paddr == hms_pkg::OFF_STATUS) || hms_pkg::hms_is_mod(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Module stop and clock stop bits
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mstop_ff <= hms_pkg::MSTOP_RST;
    end else if (moduleRst) begin
      mstop_ff <= hms_pkg::MSTOP_RST;
    end else if (wrAcc && paddr == hms_pkg::OFF_MSTOP) begin
      mstop_ff <= pwdata[7:0] & hms_pkg::MSTOP_MASK;
    end
  end

  // System control with RAM enable
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sysctl_ff <= hms_pkg::SYSCTL_RST;
    end else if (wrAcc && paddr == hms_pkg::OFF_SYSCTL) begin
      sysctl_ff <= pwdata[7:0];
    end
  end

  // Stop bits gathered in module order
  always_comb begin
    for (int i = 0; i < hms_pkg::MOD_NUM; i++) begin
      stopReq[i] = mstop_ff[hms_pkg::STOP_POS[i]];
    end
  end

  // Stop takes hold when the next bus cycle starts
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stopEff_ff <= 4'h0;
    end else if (moduleRst) begin
      stopEff_ff <= 4'h0;
    end else if (setup) begin
      stopEff_ff <= stopReq;
    end
  end
  assign modHalt = stopEff_ff;

  // ==========================================================
  // Supporting module windows
  genvar g;
  generate
    for (g = 0; g < hms_pkg::MOD_NUM; g++) begin : gMod
      assign modWr[g] = wrAcc && hms_pkg::hms_is_mod(paddr) &&
                        (hms_pkg::hms_mod_idx(paddr) == 2'(g));
      hms_mod_window uWin (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .stopped(stopEff_ff[g]),
        .sysClear(moduleRst),
        .event_i(modEvent[g]),
        .wrEn(modWr[g]),
        .wrData(pwdata[7:0]),
        .rdData(modRd[g*8 +: 8]),
        .regOut(modRegs[g*8 +: 8])
      );
    end
  endgenerate

  // Read mux
  always_comb begin
    rdSel = 8'h00;
    if (paddr == hms_pkg::OFF_MSTOP) begin
      rdSel = mstop_ff;
    end else if (paddr == hms_pkg::OFF_SYSCTL) begin
      rdSel = sysctl_ff;
    end else if (paddr == hms_pkg::OFF_STATUS) begin
      rdSel = {1'b0, stopEff_ff, state_ff};
    end else if (hms_pkg::hms_is_mod(paddr)) begin
      rdSel = modRd[hms_pkg::hms_mod_idx(paddr)*8 +: 8];
    end
  end

  // Read data captured in the setup phase, held for the access phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff <= hms_pkg::RD_ZERO;
    end else if (setup) begin
      prdata_ff <= {24'h000000, rdSel};
    end
  end
  assign prdata = prdata_ff;

  // ==========================================================
  // Pins
  assign pinCtl.portHiZ = hwStby;
  assign pinCtl.modPinRelease = stopEff_ff;

  hms_clk_out uClk (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clkStop(mstop_ff[hms_pkg::BIT_CLKSTOP]),
    .hwStby(hwStby),
    .swStby(swStandby && !sleepMode),
    .clkPin(clkPin),
    .clkPinOe(clkPinOe)
  );

  // ==========================================================
  // Checks
  sequence sStbyLow;
    !hw_standby_n;
  endsequence
  sequence sOscWait;
    hw_standby_n && !reset_in_n;
  endsequence

  hw_standby_n_entry_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sStbyLow |=> hwStby) else $error("standby not entered");
  ports_float_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    hwStby |-> pinCtl.portHiZ && !clkPinOe) else $error("pins driven in standby");
  hw_standby_n_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    hwStby |=> mstop_ff == hms_pkg::MSTOP_RST && modHalt == 4'h0) else $error("no reset");
  osc_start_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    hwStby ##0 sOscWait |=> oscRun && state_ff == hms_pkg::ST_OSC) else $error("osc idle");
  exc_then_run_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_ff == hms_pkg::ST_OSC && hw_standby_n && reset_in_n |=> resetExc
    ##1 (progRun || !hw_standby_n || !reset_in_n)) else $error("exception order");
  stop_timing_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup && !moduleRst |=> modHalt == $past(stopReq))
    else $error("stop timing");
  stop_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup && hms_pkg::hms_is_mod(paddr) && stopEff_ff[hms_pkg::hms_mod_idx(paddr)]
    && !moduleRst |=> prdata[7:0] == hms_pkg::MOD_STOP_RD) else $error("stopped read");
  stop_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    modHalt[0] |=> modRegs[7:0] == hms_pkg::MOD_RST) else $error("regs kept");
  pin_free_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup && !moduleRst |=> pinCtl.modPinRelease == $past(stopReq)) else $error("pin release");
  clk_stop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mstop_ff[hms_pkg::BIT_CLKSTOP] |-> !clkPinOe) else $error("clock pin driven");
  clk_swstby_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    swStandby && !sleepMode ##1 swStandby && !sleepMode |-> clkPin) else $error("clk low");
  stop_map_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    stopReq[0] == mstop_ff[5] && stopReq[3] == mstop_ff[0]) else $error("stop map");

  // ==========================================================
  // Exit steps after hardware standby
  // Exception lasts one cycle and hands over to the program
  sequence sExcRun;
    resetExc ##1 progRun;
  endsequence

  exc_run_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    resetExc && hw_standby_n |-> sExcRun) else $error("no run after exception");
  exc_pulse_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    resetExc |=> !resetExc) else $error("exception too long");
  mode_latch_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    resetExc |=> modeLatched == $past(modeSelectPin)) else $error("mode not latched");
  // Oscillator keeps running for as long as reset is held
  osc_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_ff == hms_pkg::ST_OSC ##0 sOscWait |=> state_ff == hms_pkg::ST_OSC && oscRun)
    else $error("oscillator wait left");

  // ==========================================================
  // Module side effects
  // Hardware standby empties every module window
  hw_standby_n_regs_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    hwStby |=> modRegs == {hms_pkg::MOD_NUM{hms_pkg::MOD_RST}}) else $error("window kept");
  // Stop bits only move when a bus cycle starts or module reset clears them
  stop_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !setup && !moduleRst |=> $stable(modHalt)) else $error("stop moved mid cycle");
  stop_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    modWr[1] && stopEff_ff[1] |=> modRegs[15:8] == hms_pkg::MOD_RST)
    else $error("stopped write kept");
  // A late event on a stopped module is dropped, not held pending
  stop_event_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    modHalt[2] && modEvent[2] |=> modRegs[23:16] == hms_pkg::MOD_RST)
    else $error("stopped event kept");

  // ==========================================================
  // Clock pin
  // Gated by run state so the reset release edge cannot trip it
  clk_toggle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    progRun && !(swStandby && !sleepMode) |=> clkPin != $past(clkPin))
    else $error("clock not toggling");
endmodule

/* File: src/hms_pkg.sv */
// Constants, types and helpers for the hardware and module standby controller.
// Assumes a single 10 MHz core clock and an APB slave with byte addresses.
// Behaviour
// - Standby pin low forces hardware standby
// - Standby halts core, resets modules, keeps RAM if its enable bit was cleared
// - Standby floats all general port pins
// - Standby high, reset low starts oscillator
// - Reset rise runs exception, then program
// - Four stop bits halt modules independently
// - Stop takes effect at next bus cycle
// - Stopped module reads FF, ignores writes
// - Stopping clears module registers and flags
// - Stopped module releases its pins
// - Clock stop bit floats clock pin
// - Clock pin state follows operating mode
package hms_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] OFF_MSTOP = 8'h00;
  localparam logic [7:0] OFF_SYSCTL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MOD_BASE = 8'h10;
  localparam logic [7:0] OFF_MOD_LAST = 8'h1C;
  localparam int unsigned MOD_NUM = 4;
  // ==========================================================
  // Field positions and reset values
  localparam int unsigned BIT_CLKSTOP = 7;
  localparam int unsigned BIT_RAM_ENABLE_BIT = 0;
  localparam int unsigned BIT_FLAG = 7;
  localparam int unsigned STOP_POS [0:3] = '{5, 4, 3, 0};
  localparam logic [7:0] MSTOP_RST = 8'h00;
  localparam logic [7:0] MSTOP_MASK = 8'hB9;
  localparam logic [7:0] SYSCTL_RST = 8'h01;
  localparam logic [7:0] MOD_RST = 8'h00;
  localparam logic [7:0] MOD_STOP_RD = 8'hFF;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_HW_STANDBY_N = 3'b001,
    ST_OSC = 3'b010,
    ST_EXC = 3'b011,
    ST_RUN = 3'b100
  } hms_state_t;
  // Pin control bundle
  typedef struct packed {
    logic portHiZ;
    logic [3:0] modPinRelease;
  } hms_pin_ctl_t;
  // ==========================================================
  // Module window decode
  function automatic logic hms_is_mod(input logic [7:0] addr);
    hms_is_mod = (addr >= OFF_MOD_BASE) && (addr <= OFF_MOD_LAST) && (addr[1:0] == 2'b00);
  endfunction
  function automatic logic [1:0] hms_mod_idx(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - OFF_MOD_BASE;
    hms_mod_idx = d[3:2];
  endfunction
endpackage

/* File: src/hms_mod_window.sv */
// One supporting module's register window under module standby control.
// Assumes write strobe is already qualified by the bus slave.
`timescale 1ns/1ps
module hms_mod_window (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Control
  input wire logic stopped,
  input wire logic sysClear,
  input wire logic event_i,
  // Register access
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  output logic [7:0] regOut
);
  logic [7:0] reg_ff;

  // ==========================================================
  // Window register; flag set beats a software clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_ff <= hms_pkg::MOD_RST;
    end else if (stopped || sysClear) begin
      reg_ff <= hms_pkg::MOD_RST;
    end else begin
      if (wrEn) begin
        reg_ff <= wrData;
      end
      if (event_i) begin
        reg_ff[hms_pkg::BIT_FLAG] <= 1'b1;
      end
    end
  end

  // Stopped module answers all ones
  assign rdData = stopped ? hms_pkg::MOD_STOP_RD : reg_ff;
  assign regOut = reg_ff;
endmodule

/* File: src/hms_clk_out.sv */
// Clock output pin driver: stop bit and operating mode select the pin state.
// Assumes one core clock; pin carries a half-rate copy built from a flip-flop.
`timescale 1ns/1ps
module hms_clk_out (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Mode
  input wire logic clkStop,
  input wire logic hwStby,
  input wire logic swStby,
  // Pin
  output logic clkPin,
  output logic clkPinOe
);
  logic phase_ff;

  // ==========================================================
  // Toggle stands for the clock; held high in software standby
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= 1'b1;
    end else if (swStby) begin
      phase_ff <= 1'b1;
    end else begin
      phase_ff <= ~phase_ff;
    end
  end

  // Float in hardware standby or when stopped
  assign clkPinOe = !clkStop && !hwStby;
  assign clkPin = phase_ff;
endmodule

/* File: testbench/hms_pwr_seq.sv */
// Model of the external power sequencer on the standby, reset and mode pins.
// Assumes the bench calls its tasks; pins move just after a rising edge.
`timescale 1ns/1ps
module hms_pwr_seq (
  // Clock
  input wire logic core_clk,
  // Pins
  output logic hw_standby_n,
  output logic reset_in_n,
  output logic [2:0] modeSelectPin
);
  // ==========================================================
  // Idle with both pins released high
  initial begin
    hw_standby_n = 1'b1;
    reset_in_n = 1'b1;
    modeSelectPin = 3'h0;
  end
  // Mode moves only outside standby, so it stays steady inside
  task automatic set_mode(input logic [2:0] m);
    @(posedge core_clk);
    modeSelectPin <= m;
  endtask
  // Reset first, then standby; a rude entry skips the reset step
  task automatic enter(input logic rude);
    @(posedge core_clk);
    if (!rude) begin
      reset_in_n <= 1'b0;
      @(posedge core_clk);
    end
    hw_standby_n <= 1'b0;
  endtask
  // Standby rises first
  task automatic wake();
    @(posedge core_clk);
    hw_standby_n <= 1'b1;
  endtask
  // Reset stays low for the settle time, short or long
  task automatic lift_reset(input int settle);
    repeat (settle) @(posedge core_clk);
    reset_in_n <= 1'b1;
  endtask
endmodule

/* File: testbench/tb_hw_and_module_standby_control.sv */
// Self-checking bench for the standby controller top.
// Assumes the pin sequencer model and the design package are compiled first.
`timescale 1ns/1ps
module tb_hw_and_module_standby_control;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, err, p0;
  logic [7:0] paddr, d, a;
  logic [31:0] pwdata, prdata, modRegs, rd;
  logic hw_standby_n, reset_in_n, swStandby, sleepMode;
  logic oscRun, cpuHalt, moduleRst, resetExc, progRun, ramHold, clkPin, clkPinOe;
  logic [2:0] modeSelectPin, modeLatched, mode;
  logic [3:0] modEvent, modHalt;
  hms_pkg::hms_pin_ctl_t pinCtl;
  int error_cnt, compares;
  // ==========================================================
  // Instances
  hms_pwr_seq pwr (.core_clk(core_clk), .hw_standby_n(hw_standby_n),
    .reset_in_n(reset_in_n), .modeSelectPin(modeSelectPin));
  hms_standby_ctl uut (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_standby_n(hw_standby_n), .reset_in_n(reset_in_n),
    .modeSelectPin(modeSelectPin), .swStandby(swStandby), .sleepMode(sleepMode),
    .modEvent(modEvent), .oscRun(oscRun), .cpuHalt(cpuHalt), .moduleRst(moduleRst),
    .resetExc(resetExc), .progRun(progRun), .ramHold(ramHold), .modeLatched(modeLatched),
    .pinCtl(pinCtl), .modHalt(modHalt), .modRegs(modRegs), .clkPin(clkPin),
    .clkPinOe(clkPinOe));
  // ==========================================================
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Compare and close
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Expected values
  function automatic logic [7:0] stop_val(input int i);
    stop_val = 8'h01 << hms_pkg::STOP_POS[i];
  endfunction
  function automatic logic [31:0] flagged(input logic [7:0] v);
    flagged = {24'h000000, v | (8'h01 << hms_pkg::BIT_FLAG)};
  endfunction
  // One APB transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h000000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait: 0 for program run, 1 for the exception pulse
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (((k == 0) ? progRun : resetExc) !== 1'b1 && n < 60);
    if (n >= 60) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {reset_n, psel, penable, pwrite, swStandby, sleepMode} = 6'h00;
    {paddr, pwdata, modEvent} = 44'h0;
    void'($urandom(92722));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_hi(0);
    apb(0, hms_pkg::OFF_SYSCTL, 8'h00);
    chk("sysctl reset", rd, {24'h0, hms_pkg::SYSCTL_RST});
    apb(0, 8'h0C, 8'h00);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    // Each module: event flag, stop, stopped access, restart
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom()) & 8'h7F;
      a = hms_pkg::OFF_MOD_BASE + 8'(4 * i);
      apb(1, a, d);
      @(posedge core_clk);
      modEvent <= 4'h1 << i;
      @(posedge core_clk);
      modEvent <= 4'h0;
      apb(0, a, 8'h00);
      chk("flag set", rd, flagged(d));
      chk("regs", {24'h0, modRegs[8 * i +: 8]}, flagged(d));
      apb(1, hms_pkg::OFF_MSTOP, stop_val(i));
      @(negedge core_clk);
      chk("halt early", {28'h0, modHalt}, 32'h0);
      apb(0, hms_pkg::OFF_STATUS, 8'h00);
      @(negedge core_clk);
      chk("halt", {28'h0, modHalt}, {28'h0, 4'h1 << i});
      chk("pins", {28'h0, pinCtl.modPinRelease}, {28'h0, 4'h1 << i});
      apb(1, a, ~d);
      // An event while stopped must be dropped, not kept pending
      modEvent <= 4'h1 << i;
      @(posedge core_clk);
      modEvent <= 4'h0;
      apb(0, a, 8'h00);
      chk("stopped read", rd, {24'h0, hms_pkg::MOD_STOP_RD});
      apb(1, hms_pkg::OFF_MSTOP, 8'h00);
      apb(0, hms_pkg::OFF_STATUS, 8'h00);
      apb(0, a, 8'h00);
      chk("cleared", rd, 32'h0);
    end
    // Clock pin: software standby, then sleep and normal toggling
    @(posedge core_clk);
    swStandby <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("pin high", {30'h0, clkPin, clkPinOe}, 32'h3);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      sleepMode <= ~k[0];
      swStandby <= ~k[0];
      @(negedge core_clk);
      p0 = clkPin;
      @(negedge core_clk);
      chk("pin toggles", {30'h0, clkPin, clkPinOe}, {30'h0, ~p0, 1'b1});
    end
    for (int k = 1; k >= 0; k--) begin
      apb(1, hms_pkg::OFF_MSTOP, 8'(k << hms_pkg::BIT_CLKSTOP));
      apb(0, hms_pkg::OFF_STATUS, 8'h00);
      @(negedge core_clk);
      chk("pin enable", {31'h0, clkPinOe}, 32'(1 - k));
    end
    // Hardware standby: ordered entry, then entry straight from run
    for (int r = 0; r < 2; r++) begin
      mode = 3'($urandom());
      pwr.set_mode(mode);
      apb(1, hms_pkg::OFF_SYSCTL, 8'h00);
      apb(1, hms_pkg::OFF_MSTOP, 8'h20);
      apb(0, hms_pkg::OFF_STATUS, 8'h00);
      pwr.enter(r[0]);
      // Stop register clears as standby shows on ordered entry, one cycle later on rude entry
      repeat (3) @(negedge core_clk);
      chk("standby", {26'h0, oscRun, cpuHalt, moduleRst, pinCtl.portHiZ, ramHold, clkPinOe},
        32'h1E);
      chk("standby halt", {28'h0, modHalt}, 32'h0);
      pwr.wake();
      if (r == 0) begin
        repeat (2) @(negedge core_clk);
        chk("osc", {30'h0, oscRun, cpuHalt}, 32'h3);
        pwr.lift_reset(2 + ($urandom() % 8));
      end
      wait_hi(1);
      @(negedge core_clk);
      chk("run", {27'h0, progRun, resetExc, modeLatched}, {27'h0, 2'b10, mode});
      apb(0, hms_pkg::OFF_SYSCTL, 8'h00);
      chk("ram bit", rd, 32'h0);
      apb(0, hms_pkg::OFF_MSTOP, 8'h00);
      chk("stop reg", rd, 32'h0);
    end
    report_and_stop();
  end
endmodule
